// ===== rtl/tsb_defines.vh
// Constants shared by the timer block: register map, fields, codes.
`ifndef TSB_DEFINES_VH
`define TSB_DEFINES_VH
// ****************************************************
// Register map (word selects in address bits 4:2, and address fields).
// ****************************************************
`define TSB_OFS_START 3'h0
`define TSB_OFS_SYNC 3'h1
`define TSB_SEL_CTRL 3'h0
`define TSB_SEL_MODE 3'h1
`define TSB_SEL_IO 3'h2
`define TSB_SEL_CNT 3'h3
`define TSB_SEL_GRA 3'h4
`define TSB_ADDR_CH 6:5
`define TSB_ADDR_SEL 4:2
`define TSB_ADDR_TOP 7
// ****************************************************
// Fields and codes.
// ****************************************************
`define TSB_PSC 2:0
`define TSB_CCS 6:4
`define TSB_MD 3:0
`define TSB_BUF_A 4
`define TSB_BUF_B 5
`define TSB_MD_PWM1 4'h2
`define TSB_MD_PWM2 4'h3
`define TSB_MD_PHASE 4'h4
`define TSB_CLR_A 3'h1
`define TSB_CLR_B 3'h2
`define TSB_CLR_SYNC 3'h3
`define TSB_CLR_C 3'h5
`define TSB_CLR_D 3'h6
`define TSB_PSC_CASCADE 3'h7
`define TSB_IO_ACT 1:0
`define TSB_IO_INIT 2
`define TSB_IO_CAP 3
`define TSB_ACT_LOW 2'h1
`define TSB_ACT_HIGH 2'h2
`define TSB_ACT_TOGGLE 2'h3
`define TSB_CNT_MAX 16'hFFFF
`define TSB_CNT_ZERO 16'h0000
`define TSB_CH_UPPER 1
`define TSB_CH_LOWER 2
`endif

// ===== rtl/tsb_pair_out.v
// Output level logic for one pair of capture/compare pins.
`timescale 1ns/100ps
`include "tsb_defines.vh"
module tsb_pair_out (
    // Clock and reset.
    input wire core_clk,
    input wire rstn,
    // Channel state.
    input wire run,
    input wire pwm1,
    input wire pwm2,
    input wire restart,
    // Pin settings and events.
    input wire [3:0] io_x,
    input wire [3:0] io_y,
    input wire hit_x,
    input wire hit_y,
    input wire same_xy,
    input wire dup_x,
    input wire dup_y,
    input wire per_x,
    input wire per_y,
    // Pin levels.
    output reg out_x,
    output reg out_y
);
    reg next_x;
    reg next_y;

    // Applies one compare action to a level.
    function act;
        input lvl;
        input [1:0] code;
        begin
            case (code)
                `TSB_ACT_LOW: act = 1'b0;
                `TSB_ACT_HIGH: act = 1'b1;
                `TSB_ACT_TOGGLE: act = ~lvl;
                default: act = lvl;
            endcase
        end
    endfunction

    // Next levels per mode.
    always @* begin
        next_x = out_x;
        next_y = out_y;
        if (!run) begin
            next_x = io_x[`TSB_IO_INIT];
            next_y = io_y[`TSB_IO_INIT];
        end else if (pwm1) begin
            next_y = io_y[`TSB_IO_INIT];
            if (!same_xy) begin
                if (hit_x)
                    next_x = act(next_x, io_x[`TSB_IO_ACT]);
                if (hit_y)
                    next_x = act(next_x, io_y[`TSB_IO_ACT]);
            end
        end else if (pwm2) begin
            if (restart) begin
                next_x = io_x[`TSB_IO_INIT];
                next_y = io_y[`TSB_IO_INIT];
            end else begin
                if (hit_x && !per_x && !dup_x)
                    next_x = act(out_x, io_x[`TSB_IO_ACT]);
                if (hit_y && !per_y && !dup_y)
                    next_y = act(out_y, io_y[`TSB_IO_ACT]);
            end
        end else begin
            if (hit_x)
                next_x = act(out_x, io_x[`TSB_IO_ACT]);
            if (hit_y)
                next_y = act(out_y, io_y[`TSB_IO_ACT]);
        end
    end

    // Level registers.
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            out_x <= 1'b0;
            out_y <= 1'b0;
        end else begin
            out_x <= next_x;
            out_y <= next_y;
        end
    end
endmodule // tsb_pair_out

// ===== rtl/tsb_timer.v
// Three-channel 16-bit timer with sync, buffer, cascade and PWM modes.
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "tsb_defines.vh"
module tsb_timer (
    // Clock and reset.
    input wire core_clk,
    input wire rstn,
    // Avalon-MM register slave.
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Phase counting inputs, bit 0 channel 1, bit 1 channel 2.
    input wire [1:0] phase_a,
    input wire [1:0] phase_b,
    // Capture/compare pins: 0-3 channel 0 A-D, 4-5 channel 1 A-B, 6-7 channel 2 A-B.
    input wire [7:0] cc_pin_in,
    output wire [7:0] cc_pin_out,
    output wire [7:0] cc_pin_oe
);
    // ****************************************************
    // State.
    // ****************************************************
    reg [2:0] channel_start_reg;
    reg [2:0] sync_select_reg;
    reg [6:0] timer_control_reg [0:2];
    reg [5:0] timer_mode_reg [0:2];
    reg [15:0] io_control_reg [0:2];
    reg [15:0] timer_count [0:2];
    reg [15:0] gr [0:7];
    reg [5:0] prescale_div;
    reg [1:0] pa_q;
    reg [1:0] pb_q;
    reg [7:0] pin_q;
    reg [2:0] adv;
    reg ack;
    // Combinational results.
    reg [7:0] ev_cmp;
    reg [7:0] ev_cap;
    reg [7:0] ev;
    reg [7:0] buf_reg;
    reg [7:0] per_pin;
    reg [7:0] dup;
    reg [2:0] own_clr;
    reg [2:0] clr;
    reg [2:0] tick;
    reg [2:0] down;
    reg [2:0] cnt_wr;
    reg [15:0] per_val [0:2];
    reg [15:0] wval;
    reg [31:0] rd_val;
    reg any_sync_clr;
    reg ovf2;
    reg udf2;
    reg [1:0] moved;
    reg [1:0] up;
    reg [1:0] slot;
    wire [1:0] wch;
    wire [2:0] wsel;
    wire ch_hit;
    wire glob_hit;
    wire wr_ok;
    integer i, c;
    integer j, n;

    // ****************************************************
    // Helper functions.
    // ****************************************************
    // Channel that owns a pin or register index.
    function [1:0] pin_ch;
        input [2:0] p;
        begin
            pin_ch = (p < 3'h4) ? 2'h0 : ((p < 3'h6) ? 2'h1 : 2'h2);
        end
    endfunction

    // Flat index of register r (0=A..3=D) of channel ch.
    function [2:0] gr_idx;
        input [1:0] ch;
        input [1:0] r;
        begin
            if (ch == 2'h0)
                gr_idx = {1'b0, r};
            else
                gr_idx = {ch, 1'b0} + {2'b0, r[0]} + 3'h2;
        end
    endfunction

    // Whether a register exists for a channel.
    function exists;
        input [1:0] ch;
        input [1:0] r;
        begin
            exists = (ch == 2'h0) || !r[1];
        end
    endfunction

    // Internal clock ticks: /1, /4, /16, /64.
    function psc_tick;
        input [2:0] sel;
        input [5:0] div;
        begin
            case (sel)
                3'h0: psc_tick = 1'b1;
                3'h1: psc_tick = (div[1:0] == 2'h0);
                3'h2: psc_tick = (div[3:0] == 4'h0);
                3'h3: psc_tick = (div == 6'h00);
                default: psc_tick = 1'b0;
            endcase
        end
    endfunction

    // Byte-lane merge of a 16-bit register.
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0] be;
        begin
            merge16[7:0] = be[0] ? nw[7:0] : old[7:0];
            merge16[15:8] = be[1] ? nw[15:8] : old[15:8];
        end
    endfunction

    // ****************************************************
    // Avalon-MM slave: one wait cycle, then the answer.
    // ****************************************************
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wch = avs_address[`TSB_ADDR_CH] - 2'h1;
    assign wsel = avs_address[`TSB_ADDR_SEL];
    assign ch_hit = !avs_address[`TSB_ADDR_TOP] && avs_address[`TSB_ADDR_CH] != 2'h0 &&
                    (wsel < `TSB_SEL_GRA || exists(wch, wsel[1:0]));
    assign glob_hit = avs_address[7:5] == 3'h0 && wsel <= `TSB_OFS_SYNC;
    assign wr_ok = avs_write & ack;

    // Read multiplexer; unmapped addresses read zero.
    always @* begin
        rd_val = 32'h0000_0000;
        if (glob_hit) begin
            if (wsel == `TSB_OFS_START)
                rd_val[2:0] = channel_start_reg;
            else
                rd_val[2:0] = sync_select_reg;
        end else if (ch_hit) begin
            case (wsel)
                `TSB_SEL_CTRL: rd_val[6:0] = timer_control_reg[wch];
                `TSB_SEL_MODE: rd_val[5:0] = timer_mode_reg[wch];
                `TSB_SEL_IO: rd_val[15:0] = io_control_reg[wch];
                `TSB_SEL_CNT: rd_val[15:0] = timer_count[wch];
                default: rd_val[15:0] = gr[gr_idx(wch, wsel[1:0])];
            endcase
        end
    end

    // Handshake and read data registers.
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack <= (avs_read | avs_write) & ~ack;
            if (avs_read && !ack)
                avs_readdata <= rd_val;
        end
    end

    // ****************************************************
    // Event, clear and tick decode.
    // ****************************************************
    always @* begin
        buf_reg = 8'h00;
        buf_reg[2] = timer_mode_reg[0][`TSB_BUF_A];
        buf_reg[3] = timer_mode_reg[0][`TSB_BUF_B];
        for (i = 0; i < 8; i = i + 1) begin
            c = pin_ch(i[2:0]);
            slot = i[1:0] & {c == 0, 1'b1}; // Channels 1 and 2 hold only A and B.
            ev_cmp[i] = adv[c] && !io_control_reg[c][{slot, 2'h3}] &&
                        timer_count[c] == gr[i] && !buf_reg[i];
            ev_cap[i] = channel_start_reg[c] && io_control_reg[c][{slot, 2'h3}] &&
                        !buf_reg[i] &&
                        ((io_control_reg[c][{slot, 2'h0}] && cc_pin_in[i] && !pin_q[i]) ||
                         (io_control_reg[c][{slot, 2'h1}] && !cc_pin_in[i] && pin_q[i]));
            ev[i] = ev_cmp[i] | ev_cap[i];
        end
        per_pin = 8'h00;
        for (c = 0; c < 3; c = c + 1) begin
            per_val[c] = `TSB_CNT_MAX;
            case (timer_control_reg[c][`TSB_CCS])
                `TSB_CLR_A: per_pin[gr_idx(c[1:0], 2'h0)] = 1'b1;
                `TSB_CLR_B: per_pin[gr_idx(c[1:0], 2'h1)] = 1'b1;
                `TSB_CLR_C: per_pin[2] = per_pin[2] | (c == 0);
                `TSB_CLR_D: per_pin[3] = per_pin[3] | (c == 0);
                default: per_pin[0] = per_pin[0];
            endcase
            own_clr[c] = 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
                if (per_pin[i] && pin_ch(i[2:0]) == c[1:0]) begin
                    own_clr[c] = ev[i];
                    per_val[c] = gr[i];
                end
            end
        end
        any_sync_clr = |(own_clr & sync_select_reg);
        for (c = 0; c < 3; c = c + 1) begin
            clr[c] = own_clr[c] | (sync_select_reg[c] && any_sync_clr &&
                     timer_control_reg[c][`TSB_CCS] == `TSB_CLR_SYNC);
            if (sync_select_reg[c] && timer_control_reg[c][`TSB_CCS] == `TSB_CLR_SYNC) begin
                for (i = 2; i >= 0; i = i - 1) begin
                    if (sync_select_reg[i] && timer_control_reg[i][`TSB_CCS] != `TSB_CLR_SYNC)
                        per_val[c] = per_val[i];
                end
            end
        end
        for (i = 0; i < 8; i = i + 1)
            dup[i] = gr[i] == per_val[pin_ch(i[2:0])];
        // Phase counting: one input moves, direction from the other.
        moved = (phase_a ^ pa_q) ^ (phase_b ^ pb_q);
        up = phase_a ^ pb_q;
        tick[0] = channel_start_reg[0] && psc_tick(timer_control_reg[0][`TSB_PSC], prescale_div);
        down[0] = 1'b0;
        if (timer_mode_reg[`TSB_CH_LOWER][`TSB_MD] == `TSB_MD_PHASE) begin
            tick[2] = channel_start_reg[2] && moved[1];
            down[2] = !up[1];
        end else begin
            tick[2] = channel_start_reg[2] &&
                      psc_tick(timer_control_reg[2][`TSB_PSC], prescale_div);
            down[2] = 1'b0;
        end
        ovf2 = tick[2] && !down[2] && timer_count[`TSB_CH_LOWER] == `TSB_CNT_MAX;
        udf2 = tick[2] && down[2] && timer_count[`TSB_CH_LOWER] == `TSB_CNT_ZERO;
        if (timer_mode_reg[`TSB_CH_UPPER][`TSB_MD] == `TSB_MD_PHASE) begin
            tick[1] = channel_start_reg[1] && moved[0];
            down[1] = !up[0];
        end else if (timer_control_reg[1][`TSB_PSC] == `TSB_PSC_CASCADE) begin
            tick[1] = channel_start_reg[1] && (ovf2 || udf2);
            down[1] = udf2;
        end else begin
            tick[1] = channel_start_reg[1] &&
                      psc_tick(timer_control_reg[1][`TSB_PSC], prescale_div);
            down[1] = 1'b0;
        end
        wval = merge16(timer_count[wch], avs_writedata[15:0], avs_byteenable[1:0]);
        for (c = 0; c < 3; c = c + 1)
            cnt_wr[c] = wr_ok && ch_hit && wsel == `TSB_SEL_CNT &&
                        (wch == c[1:0] || (sync_select_reg[c] && sync_select_reg[wch]));
    end

    // ****************************************************
    // Control registers.
    // ****************************************************
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            channel_start_reg <= 3'h0;
            sync_select_reg <= 3'h0;
            for (j = 0; j < 3; j = j + 1) begin
                timer_control_reg[j] <= 7'h00;
                timer_mode_reg[j] <= 6'h00;
                io_control_reg[j] <= 16'h0000;
            end
        end else if (wr_ok && glob_hit && avs_byteenable[0]) begin
            if (wsel == `TSB_OFS_START)
                channel_start_reg <= avs_writedata[2:0];
            else
                sync_select_reg <= avs_writedata[2:0];
        end else if (wr_ok && ch_hit) begin
            if (wsel == `TSB_SEL_CTRL && avs_byteenable[0])
                timer_control_reg[wch] <= avs_writedata[6:0];
            if (wsel == `TSB_SEL_MODE && avs_byteenable[0])
                timer_mode_reg[wch] <= avs_writedata[5:0];
            if (wsel == `TSB_SEL_IO)
                io_control_reg[wch] <= merge16(io_control_reg[wch], avs_writedata[15:0],
                                               avs_byteenable[1:0]);
        end
    end

    // ****************************************************
    // Counters, general registers and input samples.
    // ****************************************************
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prescale_div <= 6'h00;
            pa_q <= 2'h0;
            pb_q <= 2'h0;
            pin_q <= 8'h00;
            adv <= 3'h0;
            for (j = 0; j < 3; j = j + 1)
                timer_count[j] <= `TSB_CNT_ZERO;
            for (n = 0; n < 8; n = n + 1)
                gr[n] <= `TSB_CNT_MAX;
        end else begin
            prescale_div <= prescale_div + 6'h01;
            pa_q <= phase_a;
            pb_q <= phase_b;
            pin_q <= cc_pin_in;
            // Counter update: write, then clear, then count.
            for (j = 0; j < 3; j = j + 1) begin
                adv[j] <= tick[j] && !clr[j] && !cnt_wr[j];
                if (cnt_wr[j])
                    timer_count[j] <= wval;
                else if (clr[j])
                    timer_count[j] <= `TSB_CNT_ZERO;
                else if (tick[j])
                    timer_count[j] <= down[j] ? timer_count[j] - 16'h0001 :
                                                timer_count[j] + 16'h0001;
            end
            // General registers: hardware transfers win over a bus write.
            for (n = 0; n < 8; n = n + 1) begin
                if (ev_cap[n])
                    gr[n] <= timer_count[pin_ch(n[2:0])];
                else if (n < 2 && ev_cmp[n] && buf_reg[n + 2])
                    gr[n] <= gr[n + 2];
                else if (n >= 2 && n < 4 && buf_reg[n] && ev_cap[n - 2])
                    gr[n] <= gr[n - 2];
                else if (wr_ok && ch_hit && wsel >= `TSB_SEL_GRA &&
                         gr_idx(wch, wsel[1:0]) == n[2:0])
                    gr[n] <= merge16(gr[n], avs_writedata[15:0], avs_byteenable[1:0]);
            end
        end
    end

    // ****************************************************
    // Pin outputs, four pairs.
    // ****************************************************
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_pair
            localparam [1:0] CH = (k < 2) ? 2'h0 : k - 1;
            localparam [2:0] PX = 2 * k;
            localparam [2:0] PY = 2 * k + 1;
            localparam [3:0] IX = (k == 1) ? 4'h8 : 4'h0; // C/D pair sits in the upper fields.
            tsb_pair_out u_pair (
                .core_clk(core_clk),
                .rstn(rstn),
                .run(channel_start_reg[CH]),
                .pwm1(timer_mode_reg[CH][`TSB_MD] == `TSB_MD_PWM1),
                .pwm2(timer_mode_reg[CH][`TSB_MD] == `TSB_MD_PWM2),
                .restart(clr[CH]),
                .io_x(io_control_reg[CH][IX +: 4]),
                .io_y(io_control_reg[CH][IX + 4 +: 4]),
                .hit_x(ev_cmp[PX] || (PX == 3'h0 && buf_reg[2] && ev_cmp[0])),
                .hit_y(ev_cmp[PY]),
                .same_xy(gr[PX] == gr[PY]),
                .dup_x(dup[PX]),
                .dup_y(dup[PY]),
                .per_x(per_pin[PX]),
                .per_y(per_pin[PY]),
                .out_x(cc_pin_out[PX]),
                .out_y(cc_pin_out[PY])
            );
            // Pins drive unless set for capture or used as a buffer.
            assign cc_pin_oe[PX] = !io_control_reg[CH][IX + `TSB_IO_CAP] && !buf_reg[PX];
            assign cc_pin_oe[PY] = !io_control_reg[CH][IX + 4 + `TSB_IO_CAP] && !buf_reg[PY];
        end
    endgenerate
endmodule // tsb_timer

// ===== testbench/tb_tsb_timer.sv
// Self-checking testbench of the three-channel timer.
`timescale 1ns/100ps
module tb_tsb_timer;
    typedef struct packed {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;} tsb_row_t;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [7:0] cc_pin_in = 8'h00;
    logic [1:0] phase_a = 2'h0;
    logic [1:0] phase_b = 2'h0;
    wire [7:0] cc_pin_oe;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [7:0] cc_pin_out;
    int err_count = 0;
    int n_compared = 0;
    int hi;
    int tg;
    logic [15:0] rd_v;
    logic [15:0] v1;
    // Reset values, readback and unmapped places.
    tsb_row_t rows [8] = '{'{0, 8'h00, 16'h0, 16'h0}, '{0, 8'h30, 16'h0, 16'hFFFF},
        '{0, 8'h78, 16'h0, 16'h0}, '{1, 8'h88, 16'h1234, 16'h0}, '{0, 8'h88, 16'h0, 16'h0},
        '{1, 8'h54, 16'hA5A5, 16'h0}, '{0, 8'h54, 16'h0, 16'hA5A5}, '{0, 8'h20, 16'h0, 16'h0}};
    tsb_timer DUT (.core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .phase_a,
        .phase_b, .cc_pin_in, .cc_pin_out, .cc_pin_oe);
    // Clock of 20 ns period.
    always #10 core_clk = ~core_clk;
    // Prints the counts and the verdict, then ends the run.
    task print_verdict;
        begin
            $display("Compared %0d, mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    // Compares one value and reports a mismatch.
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        begin
            n_compared++;
            if (g !== e) begin
                err_count++;
                $display("Error %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // One bus access, held until the slave drops waitrequest.
    task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        begin
            avs_address <= a;
            avs_writedata <= {16'h0000, d};
            avs_write <= w;
            avs_read <= !w;
            @(posedge core_clk);
            while (avs_waitrequest) @(posedge core_clk);
            rd_v = avs_readdata[15:0];
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    // Configures a channel; the mode goes last, before any start.
    task setup(input [7:0] c, input [15:0] ct, md, io, ga, gb);
        begin
            acc(1, c, ct);
            acc(1, c + 8'h08, io);
            acc(1, c + 8'h10, ga);
            acc(1, c + 8'h14, gb);
            acc(1, c + 8'h0C, 16'h0);
            acc(1, c + 8'h04, md);
        end
    endtask
    // Counts high cycles and changes of one pin.
    task meas(input int i, input int n);
        logic p;
        begin
            hi = 0;
            tg = 0;
            p = cc_pin_out[i];
            repeat (n) begin
                @(posedge core_clk);
                hi += cc_pin_out[i];
                tg += (cc_pin_out[i] !== p);
                p = cc_pin_out[i];
            end
        end
    endtask
    // One rising and falling edge on channel 0 pin B.
    task pulse;
        begin
            cc_pin_in[1] <= 1'b1;
            repeat (4) @(posedge core_clk);
            cc_pin_in[1] <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask
    // Main sequence.
    initial begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        foreach (rows[k]) begin
            acc(rows[k].w, rows[k].a, rows[k].d);
            if (!rows[k].w) chk("table read", rows[k].e, rd_v);
        end
        // Synchronized preset on channels 0 and 1 only.
        acc(1, 8'h04, 16'h0003);
        acc(1, 8'h2C, 16'h1234);
        acc(0, 8'h4C, 16'h0);
        chk("ch1 count", 16'h1234, rd_v);
        acc(0, 8'h6C, 16'h0);
        chk("ch2 count", 16'h0000, rd_v);
        acc(0, 8'h2C, 16'h0);
        chk("ch0 stopped", 16'h1234, rd_v);
        // Channel 0 clears on its A match and drags sync-clear channel 1 along.
        acc(1, 8'h20, 16'h0010);
        acc(1, 8'h30, 16'h1240);
        acc(1, 8'h40, 16'h0030);
        acc(1, 8'h00, 16'h0003);
        repeat (30) @(posedge core_clk);
        acc(1, 8'h00, 16'h0);
        acc(0, 8'h4C, 16'h0);
        chk("ch1 sync clear", 16'h0001, 16'(rd_v < 16'h0040));
        acc(1, 8'h04, 16'h0);
        // Cascade: channel 2 overflow steps channel 1.
        setup(8'h40, 16'h0007, 16'h0, 16'h0, 16'hFFFF, 16'hFFFF);
        acc(1, 8'h6C, 16'hFFFE);
        acc(1, 8'h00, 16'h0006);
        repeat (8) @(posedge core_clk);
        acc(1, 8'h00, 16'h0);
        acc(0, 8'h4C, 16'h0);
        chk("ch1 upper", 16'h0001, rd_v);
        // Channel 2 in phase counting steps down twice; its underflow lowers channel 1.
        acc(1, 8'h64, 16'h0004);
        acc(1, 8'h6C, 16'h0001);
        acc(1, 8'h00, 16'h0006);
        phase_b <= 2'h2;
        repeat (3) @(posedge core_clk);
        phase_a <= 2'h2;
        repeat (3) @(posedge core_clk);
        acc(1, 8'h00, 16'h0);
        acc(0, 8'h4C, 16'h0);
        chk("ch1 down", 16'h0000, rd_v);
        // Channel 1 in phase counting follows its own inputs, not channel 2 overflow.
        acc(1, 8'h44, 16'h0004);
        acc(1, 8'h00, 16'h0006);
        phase_a <= 2'h0;
        phase_b <= 2'h3;
        repeat (3) @(posedge core_clk);
        acc(1, 8'h00, 16'h0);
        acc(0, 8'h4C, 16'h0);
        chk("ch1 phase", 16'hFFFF, rd_v);
        acc(0, 8'h6C, 16'h0);
        chk("ch2 wrap", 16'h0000, rd_v);
        // Buffered compare: each A match reloads A from C.
        setup(8'h20, 16'h0010, 16'h0010, 16'h0003, 16'h0005, 16'hFFFF);
        acc(1, 8'h38, 16'h0009);
        acc(1, 8'h00, 16'h0001);
        meas(0, 30);
        chk("pin0 moved", 16'h0001, 16'(tg > 0));
        acc(1, 8'h00, 16'h0);
        acc(0, 8'h30, 16'h0);
        chk("ch0 A", 16'h0009, rd_v);
        // Buffered capture: old B moves into D.
        setup(8'h20, 16'h0, 16'h0020, 16'h0090, 16'hFFFF, 16'hFFFF);
        chk("pin enables", 16'h00F5, {8'h00, cc_pin_oe});
        acc(1, 8'h00, 16'h0001);
        pulse;
        acc(0, 8'h34, 16'h0);
        v1 = rd_v;
        pulse;
        acc(0, 8'h3C, 16'h0);
        chk("ch0 D", v1, rd_v);
        acc(0, 8'h34, 16'h0);
        chk("ch0 B new", 16'h0001, 16'(rd_v !== v1));
        acc(1, 8'h00, 16'h0);
        // PWM mode 1 on channel 1 pin A, then equal pair values.
        setup(8'h40, 16'h0010, 16'h0002, 16'h0021, 16'h000A, 16'h0004);
        acc(1, 8'h00, 16'h0002);
        meas(4, 44);
        chk("pwm1 high", 16'd24, hi[15:0]);
        acc(1, 8'h00, 16'h0);
        acc(1, 8'h54, 16'h000A);
        acc(1, 8'h48, 16'h0025);
        acc(1, 8'h00, 16'h0002);
        meas(4, 44);
        chk("pwm1 equal", 16'd44, hi[15:0]);
        acc(1, 8'h00, 16'h0);
        // PWM mode 2 on channel 2 with B as period.
        setup(8'h60, 16'h0020, 16'h0003, 16'h0032, 16'h0003, 16'h0007);
        acc(1, 8'h00, 16'h0004);
        meas(6, 32);
        chk("pwm2 high", 16'd16, hi[15:0]);
        meas(7, 32);
        chk("period pin", 16'h0000, tg[15:0]);
        acc(1, 8'h70, 16'h0007);
        repeat (10) @(posedge core_clk);
        meas(6, 32);
        chk("pwm2 equal", 16'h0000, hi[15:0]);
        // Reset in mid-run clears the start bits.
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        acc(0, 8'h00, 16'h0);
        chk("start reset", 16'h0000, rd_v);
        print_verdict;
    end
    // Watchdog against a hang.
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        print_verdict;
    end
endmodule // tb_tsb_timer

// ===== testbench/tsb_timer_asserts.sv
// Checker of the timer's bus handshake and pin behaviour.
`timescale 1ns/100ps
module tsb_timer_asserts (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rstn,
    // Register bus.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Pins.
    input wire logic [7:0] cc_pin_out,
    input wire logic [7:0] cc_pin_oe
);
    logic [2:0] start_q;
    logic [2:0] wr_hist;
    // Shadow of the start bits and a short history of bus writes.
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            start_q <= 3'h0;
            wr_hist <= 3'h0;
        end else begin
            wr_hist <= {wr_hist[1:0], avs_write};
            if (avs_write && !avs_waitrequest && avs_address[7:2] == 6'h00) begin
                start_q <= avs_writedata[2:0];
            end
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("New request was not held off.");
    a_wait_once: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("Wait lasted more than one cycle.");
    a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("Wait raised with no request.");
    a_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("Unused read data bits not zero.");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[7]
        |-> avs_readdata == 32'h0000_0000) else $error("Unmapped read not zero.");
    a_data_holds: assert property (!$past(avs_read) |-> $stable(avs_readdata))
        else $error("Read data changed without a read.");
    a_oe_after_write: assert property ($changed(cc_pin_oe) |-> $past(avs_write))
        else $error("Pin enable changed without a write.");
    a_pins_idle: assert property (start_q == 3'h0 && wr_hist == 3'h0 |-> $stable(cc_pin_out))
        else $error("Pins moved while all channels stopped.");
endmodule // tsb_timer_asserts
bind tsb_timer tsb_timer_asserts u_chk (.core_clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .cc_pin_out, .cc_pin_oe);
